// ==== rtl/walker_pkg.sv ====
// walker_pkg: constants and carriers of the queue schedule walker
// assumes: one 10 MHz clock, link words as 32-bit words in system memory
package walker_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // link word layout
  localparam int LINK_T_BIT = 0;
  localparam int LINK_Q_BIT = 1;
  localparam int LINK_VF_BIT = 2;
  localparam int LINK_ADDR_LSB = 4;
  localparam logic [31:0] NEXT_WORD_OFS = 32'h0000_0004;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int AXI_AW = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ENTRY_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ADV_CNT_OFS = 8'h0C;
  localparam logic [7:0] RETRY_CNT_OFS = 8'h10;
  localparam logic [7:0] FRAME_CNT_OFS = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_QCTX_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ENTRY_RST = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // completion codes from the transaction engine
  localparam logic [1:0] CPL_DATA = 2'h0;
  localparam logic [1:0] CPL_NULL = 2'h1;
  localparam logic [1:0] CPL_ERROR = 2'h2;
  localparam logic [1:0] CPL_NAK = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] td_addr;
    logic [31:0] td_link;
  } exec_req_s;

endpackage

// ==== rtl/usb_queue_schedule_walker.sv ====
// usb_queue_schedule_walker: walks queue headers and transfer descriptors per frame
// assumes: memory answers each request with a one-cycle mem_ack, the transaction
// engine answers each exec request with a one-cycle exec_done and a completion code
`timescale 1ns/1ps

module usb_queue_schedule_walker
  import walker_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_start,
  output mem_req_s mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output exec_req_s exec_req,
  input wire logic exec_done,
  input wire logic [1:0] exec_cpl,
  output logic frame_end
);

  // refuse counter widths that the 32-bit read word cannot carry
  if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_w_check
    $error("CNT_W must lie between 1 and 32");
  end

  typedef enum {
    ST_IDLE,
    ST_DISPATCH,
    ST_RD_H,
    ST_RD_V,
    ST_QDECIDE,
    ST_RD_TD,
    ST_EXEC,
    ST_WB,
    ST_END
  } walk_e;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] link_addr(input logic [31:0] link);
    link_addr = {link[31:LINK_ADDR_LSB], {LINK_ADDR_LSB{1'b0}}};
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  walk_e state_ff;
  logic [31:0] cur_link_ff;
  logic [31:0] qh_addr_ff;
  logic [31:0] qh_h_ff;
  logic [31:0] qh_v_ff;
  logic [31:0] td_addr_ff;
  logic [31:0] td_link_ff;
  logic qctx_ff;
  logic [CNT_W-1:0] adv_cnt_ff;
  logic [CNT_W-1:0] retry_cnt_ff;
  logic [CNT_W-1:0] frame_cnt_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] entry_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;
  logic advance;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;

  assign wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign advance = (exec_cpl == CPL_DATA) || (exec_cpl == CPL_NULL);

  ////////////////////////////////////////////////////////////////////////////
  // schedule walker

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      cur_link_ff <= 32'h0000_0001;
      qh_addr_ff <= 32'h0000_0000;
      qh_h_ff <= 32'h0000_0001;
      qh_v_ff <= 32'h0000_0001;
      td_addr_ff <= 32'h0000_0000;
      td_link_ff <= 32'h0000_0001;
      qctx_ff <= 1'b0;
      mem_req <= '0;
      exec_req <= '0;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (frame_start && ctrl_ff[CTRL_EN_BIT]) begin
            cur_link_ff <= entry_ff;
            qctx_ff <= 1'b0;
            state_ff <= ST_DISPATCH;
          end
        end
        ST_DISPATCH: begin
          if (cur_link_ff[LINK_T_BIT]) begin
            state_ff <= ST_END;
          end else if (cur_link_ff[LINK_Q_BIT]) begin
            qh_addr_ff <= link_addr(cur_link_ff);
            qctx_ff <= 1'b1;
            mem_req.valid <= 1'b1;
            mem_req.write <= 1'b0;
            mem_req.addr <= link_addr(cur_link_ff);
            state_ff <= ST_RD_H;
          end else begin
            td_addr_ff <= link_addr(cur_link_ff);
            mem_req.valid <= 1'b1;
            mem_req.write <= 1'b0;
            mem_req.addr <= link_addr(cur_link_ff);
            state_ff <= ST_RD_TD;
          end
        end
        ST_RD_H: begin
          if (mem_ack) begin
            qh_h_ff <= mem_rdata;
            mem_req.addr <= qh_addr_ff + NEXT_WORD_OFS;
            state_ff <= ST_RD_V;
          end
        end
        ST_RD_V: begin
          if (mem_ack) begin
            qh_v_ff <= mem_rdata;
            mem_req.valid <= 1'b0;
            state_ff <= ST_QDECIDE;
          end
        end
        ST_QDECIDE: begin
          if (qh_v_ff[LINK_T_BIT]) begin
            cur_link_ff <= qh_h_ff;
            state_ff <= ST_DISPATCH;
          end else if (qh_v_ff[LINK_Q_BIT]) begin
            cur_link_ff <= qh_v_ff;
            state_ff <= ST_DISPATCH;
          end else begin
            td_addr_ff <= link_addr(qh_v_ff);
            mem_req.valid <= 1'b1;
            mem_req.write <= 1'b0;
            mem_req.addr <= link_addr(qh_v_ff);
            state_ff <= ST_RD_TD;
          end
        end
        ST_RD_TD: begin
          if (mem_ack) begin
            td_link_ff <= mem_rdata;
            mem_req.valid <= 1'b0;
            exec_req.valid <= 1'b1;
            exec_req.td_addr <= td_addr_ff;
            exec_req.td_link <= mem_rdata;
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            exec_req.valid <= 1'b0;
            if (!qctx_ff) begin
              cur_link_ff <= td_link_ff;
              state_ff <= ST_DISPATCH;
            end else if (advance) begin
              qh_v_ff <= td_link_ff;
              mem_req.valid <= 1'b1;
              mem_req.write <= 1'b1;
              mem_req.addr <= qh_addr_ff + NEXT_WORD_OFS;
              mem_req.wdata <= td_link_ff;
              state_ff <= ST_WB;
            end else begin
              cur_link_ff <= qh_h_ff;
              state_ff <= ST_DISPATCH;
            end
          end
        end
        ST_WB: begin
          if (mem_ack) begin
            mem_req.valid <= 1'b0;
            mem_req.write <= 1'b0;
            if (td_link_ff[LINK_VF_BIT]) begin
              state_ff <= ST_QDECIDE;
            end else begin
              cur_link_ff <= qh_h_ff;
              state_ff <= ST_DISPATCH;
            end
          end
        end
        ST_END: begin
          frame_end <= 1'b1;
          qctx_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // statistics

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_cnt_ff <= '0;
      retry_cnt_ff <= '0;
      frame_cnt_ff <= '0;
    end else begin
      if (state_ff == ST_EXEC && exec_done && qctx_ff) begin
        if (advance) begin
          adv_cnt_ff <= adv_cnt_ff + 1'b1;
        end else begin
          retry_cnt_ff <= retry_cnt_ff + 1'b1;
        end
      end
      if (state_ff == ST_END) begin
        frame_cnt_ff <= frame_cnt_ff + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_hold_ff && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_hold_ff && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_ff == CTRL_OFS || awaddr_ff == ENTRY_OFS) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      entry_ff <= ENTRY_RST;
    end else if (wr_fire) begin
      if (awaddr_ff == CTRL_OFS) begin
        ctrl_ff <= apply_strb(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_0001;
      end
      if (awaddr_ff == ENTRY_OFS) begin
        entry_ff <= apply_strb(entry_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
    status_word[STAT_QCTX_BIT] = qctx_ff;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: rd_word = ctrl_ff;
      ENTRY_OFS: rd_word = entry_ff;
      STATUS_OFS: rd_word = status_word;
      ADV_CNT_OFS: rd_word = 32'(adv_cnt_ff);
      RETRY_CNT_OFS: rd_word = 32'(retry_cnt_ff);
      FRAME_CNT_OFS: rd_word = 32'(frame_cnt_ff);
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ==== verif/walker_mem_model.sv ====
// walker_mem_model: system memory holding the schedule words
// assumes: one request at a time, word index from addr[7:2], ack after 0 to 3 cycles
`timescale 1ns/1ps
module walker_mem_model
  import walker_pkg::*;
(
  input wire logic aclk,
  input wire mem_req_s mem_req,
  output logic mem_ack = 1'b0,
  output logic [31:0] mem_rdata = 32'h0000_0000
);
  logic [31:0] mem [64];
  int seed = 87103;
  int wait_n = 0;
  // schedule words are built by the bench with every chain terminated
  always @(posedge aclk) begin
    if (mem_req.valid === 1'b1 && !mem_ack && wait_n == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_req.addr[7:2]];
      if (mem_req.write) mem[mem_req.addr[7:2]] <= mem_req.wdata;
      wait_n <= $unsigned($random(seed)) % 4;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid === 1'b1 && !mem_ack) wait_n <= wait_n - 1;
    end
  end
endmodule

// ==== verif/walker_properties.sv ====
// walker_checker: port-level properties of the schedule walker
// assumes: bound to usb_queue_schedule_walker, one aclk domain
`timescale 1ns/1ps
module walker_checker
  import walker_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire mem_req_s mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire exec_req_s exec_req,
  input wire logic exec_done,
  input wire logic [1:0] exec_cpl,
  input wire logic frame_end
);
  logic [31:0] link_ff;
  logic [31:0] qaddr_ff;
  logic ok_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ok_ff <= 1'b0;
    end else if (exec_done) begin
      ok_ff <= !exec_cpl[1];
      link_ff <= exec_req.td_link;
    end else if (mem_ack && mem_req.write) begin
      ok_ff <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (mem_ack && !mem_req.write && mem_req.addr[2]) begin
      qaddr_ff <= mem_req.addr;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_mem_hold: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
    else $error("memory request changed before ack");
  a_exec_hold: assert property (exec_req.valid && !exec_done |=> $stable(exec_req))
    else $error("exec request changed before done");
  a_exec_drop: assert property (exec_done |=> !exec_req.valid)
    else $error("exec request held after done");
  a_exec_cause: assert property ($rose(exec_req.valid) |->
    $past(mem_ack) && exec_req.td_link == $past(mem_rdata))
    else $error("exec request not from descriptor read");
  a_wb_link: assert property (mem_req.valid && mem_req.write |->
    ok_ff && mem_req.wdata == link_ff)
    else $error("write-back without success or wrong link");
  a_wb_addr: assert property (mem_req.valid && mem_req.write |-> mem_req.addr == qaddr_ff)
    else $error("write-back not to current header");
  a_err_nowb: assert property (exec_done && exec_cpl[1] |=>
    !(mem_req.valid && mem_req.write) [*3])
    else $error("queue advanced after failed completion");
  a_end_quiet: assert property (frame_end |=>
    !frame_end && !mem_req.valid && !exec_req.valid)
    else $error("activity after frame end");
  c_wb: cover property (mem_ack && mem_req.write);
  c_retry: cover property (exec_done && exec_cpl[1]);
  c_end: cover property (frame_end);
endmodule
bind usb_queue_schedule_walker walker_checker u_walker_checker (.aclk, .aresetn, .mem_req,
  .mem_ack, .mem_rdata, .exec_req, .exec_done, .exec_cpl, .frame_end);

// ==== verif/test_usb_queue_schedule_walker.sv ====
// test_usb_queue_schedule_walker: random completions over a fixed schedule
// assumes: walker_mem_model as memory, transaction engine modelled here
`timescale 1ns/1ps
module test_usb_queue_schedule_walker;
  import walker_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, frame_start = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, mem_rdata, entry;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, exec_done = 1'b0;
  logic [1:0] exec_cpl = 2'h0, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_ack, frame_end;
  mem_req_s mem_req;
  exec_req_s exec_req;
  logic [31:0] em [64];
  logic [31:0] ea [$];
  logic [1:0] cq [8];
  int seed = 87103, ni = 0, n_fail = 0, tests_run = 0;
  int n_adv = 0, n_ret = 0, n_frm = 0;
  usb_queue_schedule_walker u_usb_queue_schedule_walker (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_start, .mem_req,
    .mem_ack, .mem_rdata, .exec_req, .exec_done, .exec_cpl, .frame_end);
  walker_mem_model u_walker_mem_model (.aclk, .mem_req, .mem_ack, .mem_rdata);
  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // expected descriptor order and memory after one frame
  task automatic ref_walk;
    logic [31:0] lk;
    int qh, a;
    lk = entry;
    qh = -1;
    ea.delete();
    for (int k = 0; k < 40 && !lk[0]; k++) begin
      a = int'({lk[7:4], 2'b00});
      if (lk[1]) begin
        qh = a;
        lk = em[a + 1];
        if (lk[0]) lk = em[a];
      end else begin
        ea.push_back({lk[31:4], 4'h0});
        if (qh < 0) lk = em[a];
        else if (cq[ea.size() - 1][1]) begin
          lk = em[qh];
          n_ret++;
        end else begin
          n_adv++;
          em[qh + 1] = em[a];
          lk = (em[a][2] && !em[a][0]) ? em[a] : em[qh];
        end
      end
    end
  endtask
  task automatic run_frame(input int f);
    int t;
    for (int i = 0; i < 64; i++) em[i] = u_walker_mem_model.mem[i];
    for (int i = 0; i < 8; i++) cq[i] = (f == 0) ? 2'(i) : 2'($random(seed));
    ref_walk();
    ni = 0;
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    t = 0;
    while (frame_end !== 1'b1 && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    chk(32'(frame_end === 1'b1), 32'h0000_0001);
    n_frm++;
    chk(32'(ni), 32'(ea.size()));
    for (int i = 0; i < 64; i++) chk(u_walker_mem_model.mem[i], em[i]);
    $display("frame %0d done", f);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever begin
      @(posedge aclk);
      if (exec_req.valid === 1'b1) begin
        chk(exec_req.td_addr, ea[ni]);
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        exec_done <= 1'b1;
        exec_cpl <= cq[ni];
        ni++;
        @(posedge aclk);
        exec_done <= 1'b0;
      end
    end
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    // schedule: td, queue with two tds, queue holding a nested queue
    for (int i = 0; i < 64; i++) u_walker_mem_model.mem[i] = 32'h0000_0001;
    u_walker_mem_model.mem[4] = 32'h0000_0022;
    u_walker_mem_model.mem[8] = 32'h0000_0032;
    u_walker_mem_model.mem[9] = 32'h0000_0040;
    u_walker_mem_model.mem[16] = 32'h0000_0050;
    u_walker_mem_model.mem[13] = 32'h0000_0062;
    u_walker_mem_model.mem[25] = 32'h0000_0070;
    u_walker_mem_model.mem[28] = 32'h0000_0084;
    u_walker_mem_model.mem[32] = 32'h0000_0005;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(CTRL_OFS, d, r);
    chk(d, CTRL_RST);
    axi_rd(ENTRY_OFS, d, r);
    chk(d, ENTRY_RST);
    axi_rd(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(STATUS_OFS, 32'h0000_0003, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(CTRL_OFS, 32'h0000_0001, r);
    chk(32'(r), 32'(RESP_OKAY));
    $display("registers done");
    entry = ENTRY_RST;
    run_frame(-1);
    entry = 32'h0000_0010;
    // only the low byte lane is enabled, upper bytes must stay as they were
    s_axi_wstrb <= 4'h1;
    axi_wr(ENTRY_OFS, 32'hFFFF_FF10, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(ENTRY_OFS, d, r);
    chk(d, entry);
    for (int f = 0; f < 6; f++) run_frame(f);
    axi_rd(ADV_CNT_OFS, d, r);
    chk(d, 32'(n_adv));
    axi_rd(RETRY_CNT_OFS, d, r);
    chk(d, 32'(n_ret));
    axi_rd(FRAME_CNT_OFS, d, r);
    chk(d, 32'(n_frm));
    axi_rd(STATUS_OFS, d, r);
    chk(d, 32'h0000_0000);
    $display("counters done");
    test_done();
  end
endmodule
